// [hw/hbdc_seq.sv]
// Read strobe and chip-select sequencer of the external parallel interface host bus
// Functional notes
// - Only dual selects (0x2) with continuous read (0x2) give the wrong-select first read.
// - On that first read the other chip select asserts together with the read strobe.
// - The wrong chip select is released on the next interface clock edge after it rose.
// - On that edge the chip select owning the region asserts, completing the handover.
// - The read strobe holds across the handover; its count includes the wrong-select clock.
// - Read-wait 0x0 gives a two-clock strobe, one clock wrong select and one correct.
// - Later reads under the same output enable drive only the correct select, normal timing.
// - Read-wait 0x2 gives a six-clock strobe, five of them under the correct select.
`timescale 1ns/100ps
`default_nettype none
`include "hbdc_cfg.svh"
module hbdc_seq (
    input wire logic mclk,
    input wire logic srst,
    input wire hbdc_pkg::hbdc_cfg_t cfg,
    input wire logic req_valid,
    input wire logic req_region,
    input wire logic req_last,
    output logic req_ready,
    output logic rd_done,
    output var hbdc_pkg::hbdc_pins_t pins
);
    import hbdc_pkg::*;

    hbdc_state_t state_q;
    logic [3:0] cnt_q;
    logic region_q;
    logic first_q;
    logic last_q;
    logic faulty_mode;
    logic [3:0] strobe_len;
    logic wrong_phase;
    logic [3:0] rd_len_q;

    // Fault condition: dual selects in continuous-read mode
    // Every other setting drives the owning select alone from the first strobe clock
    assign faulty_mode = (cfg.chip_select_config_field == `HBDC_CSEL_DUAL) &&
                         (cfg.mode == `HBDC_MODE_CONTREAD);
    // Strobe length: two clocks plus two per read-wait step
    assign strobe_len = `HBDC_STROBE_BASE +
                        4'({2'h0, cfg.read_wait_field} * `HBDC_STROBE_STEP);
    // Wrong select only during first strobe clock of the first read
    assign wrong_phase = (state_q == ST_READ) && first_q && faulty_mode &&
                         (cnt_q < `HBDC_WRONG_CS_CYCLES);
    // Ready outside strobes, so a queued read is taken in the one-clock gap
    assign req_ready = (state_q != ST_READ);

    // Sequencer state
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            region_q <= 1'b0;
            first_q <= 1'b1;
            last_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE, ST_HOLD: begin
                    if (req_valid) begin
                        state_q <= ST_READ;
                        cnt_q <= 4'h0;
                        region_q <= req_region;
                        last_q <= req_last;
                        first_q <= (state_q == ST_IDLE);
                    end else if (state_q == ST_HOLD && last_q) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_READ: begin
                    // Count includes the wrong-select clock, strobe never drops
                    if (cnt_q == strobe_len - 4'h1) begin
                        state_q <= last_q ? ST_IDLE : ST_HOLD;
                        first_q <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
            endcase
        end
    end

    // Registered completion pulse
    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_done <= 1'b0;
        end else begin
            rd_done <= (state_q == ST_READ) && (cnt_q == strobe_len - 4'h1);
        end
    end

    // Strobe run length seen on the pin, for the length checks
    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_len_q <= 4'h0;
        end else if (pins.rd) begin
            rd_len_q <= rd_len_q + 4'h1;
        end else begin
            rd_len_q <= 4'h0;
        end
    end

    // Pin drive: select owner takes over on the edge ending the wrong phase
    always_comb begin
        pins.rd = (state_q == ST_READ);
        pins.oe = (state_q != ST_IDLE);
        pins.cs0 = 1'b0;
        pins.cs1 = 1'b0;
        if (state_q == ST_READ) begin
            if (wrong_phase) begin
                pins.cs0 = region_q;
                pins.cs1 = !region_q;
            end else begin
                pins.cs0 = !region_q;
                pins.cs1 = region_q;
            end
        end
    end

    property p_wrong_one_clock;
        @(posedge mclk) disable iff (srst)
        wrong_phase |=> !wrong_phase;
    endproperty
    a_wrong_one_clock: assert property (p_wrong_one_clock) else $error("select held");

    property p_handover;
        @(posedge mclk) disable iff (srst)
        (wrong_phase && pins.rd) |=> (pins.rd && (pins.cs0 == !region_q) && (pins.cs1 == region_q));
    endproperty
    a_handover: assert property (p_handover) else $error("handover missing");

    property p_only_faulty;
        @(posedge mclk) disable iff (srst)
        (pins.rd && (pins.cs0 == region_q) && (pins.cs1 == !region_q)) |->
            (faulty_mode && first_q);
    endproperty
    a_only_faulty: assert property (p_only_faulty) else $error("wrong select outside mode");

    property p_rd_with_wrong;
        @(posedge mclk) disable iff (srst)
        $rose(pins.rd) && first_q && faulty_mode |-> wrong_phase;
    endproperty
    a_rd_with_wrong: assert property (p_rd_with_wrong) else $error("no wrong select");

    property p_two_clock;
        @(posedge mclk) disable iff (srst)
        ($rose(pins.rd) && cfg.read_wait_field == `HBDC_RWAIT_MIN) |->
            pins.rd ##1 pins.rd ##1 !pins.rd;
    endproperty
    a_two_clock: assert property (p_two_clock) else $error("strobe not two clocks");

    property p_six_clock;
        @(posedge mclk) disable iff (srst)
        ($rose(pins.rd) && cfg.read_wait_field == `HBDC_RWAIT_W6) |-> pins.rd [*6] ##1 !pins.rd;
    endproperty
    a_six_clock: assert property (p_six_clock) else $error("strobe not six clocks");

    property p_later_clean;
        @(posedge mclk) disable iff (srst)
        (pins.rd && !first_q) |-> (pins.cs0 == !region_q);
    endproperty
    a_later_clean: assert property (p_later_clean) else $error("later read wrong select");

    property p_one_select;
        @(posedge mclk) disable iff (srst)
        pins.rd |-> (pins.cs0 ^ pins.cs1);
    endproperty
    a_one_select: assert property (p_one_select) else $error("selects overlap");

    // Pin checks: outside the fault mode the owner select is the only one ever seen
    property p_owner_only;
        @(posedge mclk) disable iff (srst)
        (pins.rd && !faulty_mode) |-> (pins.cs0 == !region_q) && (pins.cs1 == region_q);
    endproperty
    a_owner_only: assert property (p_owner_only) else $error("owner select missing");

    property p_wrong_at_rise;
        @(posedge mclk) disable iff (srst)
        ($rose(pins.rd) && first_q && faulty_mode) |->
            (pins.cs0 == region_q) && (pins.cs1 == !region_q);
    endproperty
    a_wrong_at_rise: assert property (p_wrong_at_rise) else $error("early select");

    // After the first strobe clock only the owner may be selected
    property p_owner_after;
        @(posedge mclk) disable iff (srst)
        (pins.rd && $past(pins.rd)) |-> (pins.cs0 == !region_q) && (pins.cs1 == region_q);
    endproperty
    a_owner_after: assert property (p_owner_after) else $error("owner select late");

    // Strobe width counts the wrong-select clock, so it is the programmed one
    property p_strobe_length;
        @(posedge mclk) disable iff (srst)
        $fell(pins.rd) |-> (rd_len_q == 4'(`HBDC_STROBE_BASE +
            `HBDC_STROBE_STEP * {2'h0, cfg.read_wait_field}));
    endproperty
    a_strobe_length: assert property (p_strobe_length) else $error("strobe length off");

    property p_done_on_fall;
        @(posedge mclk) disable iff (srst)
        $fell(pins.rd) |-> rd_done;
    endproperty
    a_done_on_fall: assert property (p_done_on_fall) else $error("done missing");

    property p_done_pulse;
        @(posedge mclk) disable iff (srst)
        rd_done |=> !rd_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");

    // Output enable spans a continuous run and drops only after its last read
    property p_oe_at_done;
        @(posedge mclk) disable iff (srst)
        rd_done |-> (pins.oe == !last_q);
    endproperty
    a_oe_at_done: assert property (p_oe_at_done) else $error("enable wrong at end");

    property p_rd_in_oe;
        @(posedge mclk) disable iff (srst)
        pins.rd |-> (pins.oe && !req_ready);
    endproperty
    a_rd_in_oe: assert property (p_rd_in_oe) else $error("strobe outside enable");
endmodule
`default_nettype wire

// [hw/hbdc_cfg.svh]
// Constants for the dual chip-select continuous-read host-bus sequencer
`ifndef HBDC_CFG_SVH
`define HBDC_CFG_SVH
`define HBDC_CSEL_DUAL 2'h2
`define HBDC_MODE_CONTREAD 2'h2
`define HBDC_RWAIT_MIN 2'h0
`define HBDC_RWAIT_W6 2'h2
`define HBDC_STROBE_BASE 4'h2
`define HBDC_STROBE_STEP 4'h2
`define HBDC_WRONG_CS_CYCLES 4'h1
`endif

// [hw/hbdc_pkg.sv]
// Types for the dual chip-select continuous-read host-bus sequencer
`default_nettype none
package hbdc_pkg;
    typedef struct packed {
        logic [1:0] chip_select_config_field;
        logic [1:0] mode;
        logic [1:0] read_wait_field;
    } hbdc_cfg_t;
    typedef struct packed {
        logic rd;
        logic cs0;
        logic cs1;
        logic oe;
    } hbdc_pins_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_HOLD = 3'b100
    } hbdc_state_t;
endpackage
`default_nettype wire

// [verification/hbdc_mem_model.sv]
// Far-side memory model counting strobe clocks under each chip select
`timescale 1ns/100ps
`default_nettype none
module hbdc_mem_model (
    input wire logic mclk,
    input wire hbdc_pkg::hbdc_pins_t pins,
    output logic [3:0] n0,
    output logic [3:0] n1
);
    import hbdc_pkg::*;
    logic rd_q;
    // Clocks with exactly one select, restarted at each new strobe
    always_ff @(posedge mclk) begin
        rd_q <= pins.rd;
        if (pins.rd) begin
            n0 <= (rd_q ? n0 : 4'h0) + {3'h0, pins.cs0 & ~pins.cs1};
            n1 <= (rd_q ? n1 : 4'h0) + {3'h0, pins.cs1 & ~pins.cs0};
        end
    end
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the dual-select continuous-read sequencer
`timescale 1ns/100ps
`default_nettype none
`include "hbdc_cfg.svh"
module testbench;
    import hbdc_pkg::*;
    logic mclk = 1'b0, srst = 1'b1, req_valid = 1'b0, req_region = 1'b0, req_last = 1'b0;
    logic req_ready, rd_done, first = 1'b1;
    hbdc_cfg_t cfg = '0;
    hbdc_pins_t pins;
    logic [3:0] n0, n1;
    logic [8:0] exp_q[$];
    int err_count = 0, samples_checked = 0, seed = 25536;
    hbdc_seq i_dut (.mclk(mclk), .srst(srst), .cfg(cfg), .req_valid(req_valid),
        .req_region(req_region), .req_last(req_last), .req_ready(req_ready),
        .rd_done(rd_done), .pins(pins));
    hbdc_mem_model i_mem (.mclk(mclk), .pins(pins), .n0(n0), .n1(n1));
    initial forever #5 mclk = ~mclk;
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Hold a request until taken, then note the select counts it should give
    task automatic rd_req(input logic region, input logic last);
        logic [3:0] len, bad;
        if (req_valid !== 1'b1) req_valid <= 1'b1;
        req_region <= region;
        req_last <= last;
        for (int k = 0; k < 50; k++) begin
            @(negedge mclk);
            if (req_ready === 1'b1) break;
        end
        if (req_ready !== 1'b1) check(9'h000, 9'h1ff);
        @(posedge mclk);
        len = `HBDC_STROBE_BASE + `HBDC_STROBE_STEP * cfg.read_wait_field;
        bad = {3'h0, first && cfg.chip_select_config_field == `HBDC_CSEL_DUAL
            && cfg.mode == `HBDC_MODE_CONTREAD};
        exp_q.push_back(region ? {!last, bad, len - bad} : {!last, len - bad, bad});
        first = last;
    endtask
    // Oldest note against the far side's counts at each completion pulse
    always @(posedge mclk) begin
        if (!srst && rd_done === 1'b1) begin
            if (exp_q.size() == 0) check(9'h1ff, 9'h000);
            else check({pins.oe, n0, n1}, exp_q.pop_front());
        end
    end
    // Runs of one to three reads under varied and random settings
    initial begin
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            cfg.chip_select_config_field <= i[0] ? 2'h2 : 2'($random(seed));
            cfg.mode <= i[1] ? 2'h2 : 2'($random(seed));
            cfg.read_wait_field <= (i < 8) ? (i[2] ? 2'h2 : 2'h0) : 2'($random(seed));
            @(posedge mclk);
            for (int r = 0; r <= i % 3; r++) rd_req(1'($random(seed)), r == i % 3);
            req_valid <= 1'b0;
            repeat (20) @(posedge mclk);
        end
        check(9'(exp_q.size()), 9'h000);
        finish_test();
    end
    // Cut a hang short
    initial begin
        #200000;
        err_count++;
        finish_test();
    end
endmodule
`default_nettype wire
